/* File: src/bwcrc_pkg.sv */
// Package with register map, field layout and reset values of the CRC unit
package bwcrc_pkg;
	// Byte addresses of the registers on APB
	localparam logic [11:0] BWCRC_CONTROL_ADDR = 12'h000;
	localparam logic [11:0] BWCRC_INPUT_ADDR = 12'h004;
	localparam logic [11:0] BWCRC_SUM_LOW_ADDR = 12'h008;
	localparam logic [11:0] BWCRC_SUM_HIGH_ADDR = 12'h00C;
	// Field position of the polynomial select bit
	localparam int BWCRC_CHOICE_BIT = 0;
	// Reset values
	localparam logic BWCRC_CHOICE_RST = 1'h0;
	localparam logic [7:0] BWCRC_INPUT_RST = 8'h00;
	localparam logic [15:0] BWCRC_SUM_RST = 16'h0000;
	// Feedback values of the two generator polynomials
	localparam logic [15:0] BWCRC_GENERATOR_CHOICE_CCITT = 16'h1021;
	localparam logic [15:0] BWCRC_GENERATOR_CHOICE_CRC16 = 16'h8005;
	// Number of shift steps per byte
	localparam int BWCRC_STEPS = 8;
endpackage

/* File: src/byte_wise_crc16_unit.sv */
// APB register slave and byte-wise 16-bit CRC datapath
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module bwcrc_byte_wise_crc16_unit
	import bwcrc_pkg::*;
(
	input wire logic clk, // 50 MHz system clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data, from flip-flops
	output logic pready, // APB ready, always high
	output logic pslverr // APB error for unmapped address
);

	logic generatorChoice_r; // Polynomial select bit
	logic [7:0] crcInputByte_r; // Last byte written to input register
	logic [15:0] runningChecksum_r; // Stored checksum pair
	logic [15:0] foldedSum; // Checksum after folding the written byte
	logic [15:0] polyValue; // Feedback value picked by select bit
	logic [31:0] readValue; // Combinational read mux
	logic mapped; // Address hits a register
	logic wrAccess; // Write completing this edge
	logic rdAccess; // Read in its setup phase this edge
	logic laneWrite; // Byte lane 0 is written

	// Access decode, zero-wait slave
	assign pready = 1'b1;
	assign mapped = (paddr == BWCRC_CONTROL_ADDR)
		|| (paddr == BWCRC_INPUT_ADDR)
		|| (paddr == BWCRC_SUM_LOW_ADDR)
		|| (paddr == BWCRC_SUM_HIGH_ADDR);
	assign pslverr = psel && penable && !mapped;
	assign wrAccess = psel && penable && pwrite && mapped;
	assign rdAccess = psel && !penable && !pwrite;
	assign laneWrite = pstrb[0];

	// Only two fixed feedback values, no programmable one
	assign polyValue = generatorChoice_r ? BWCRC_GENERATOR_CHOICE_CRC16
		: BWCRC_GENERATOR_CHOICE_CCITT;

	// Chain of eight shift stages, one per data bit
	logic [15:0] stageSum [0:BWCRC_STEPS]; // Partial sums between steps

	// Byte first goes into the high half of the stored checksum
	assign stageSum[0] = runningChecksum_r ^ {pwdata[7:0], 8'h00};

	// Each stage shifts left, feeding back when a one drops out
	for (genvar k = 0; k < BWCRC_STEPS; k++)
	begin : g_step
		// Feedback applied only after a one has left bit 15
		assign stageSum[k + 1] = stageSum[k][15]
			? ({stageSum[k][14:0], 1'b0} ^ polyValue)
			: {stageSum[k][14:0], 1'b0};
	end

	// Whole byte folded within the same cycle
	assign foldedSum = stageSum[BWCRC_STEPS];

	// Polynomial select register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			generatorChoice_r <= BWCRC_CHOICE_RST;
		else if (wrAccess && laneWrite && paddr == BWCRC_CONTROL_ADDR)
			generatorChoice_r <= pwdata[BWCRC_CHOICE_BIT];
	end

	// Input byte register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			crcInputByte_r <= BWCRC_INPUT_RST;
		else if (wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR)
			crcInputByte_r <= pwdata[7:0];
	end

	// Checksum pair: updated by input writes or loaded by software
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			runningChecksum_r <= BWCRC_SUM_RST;
		else if (wrAccess && laneWrite)
		begin
			// Input write folds byte in the same edge
			if (paddr == BWCRC_INPUT_ADDR)
				runningChecksum_r <= foldedSum;
			// Direct preset of the low byte
			else if (paddr == BWCRC_SUM_LOW_ADDR)
				runningChecksum_r[7:0] <= pwdata[7:0];
			// Direct preset of the high byte
			else if (paddr == BWCRC_SUM_HIGH_ADDR)
				runningChecksum_r[15:8] <= pwdata[7:0];
		end
		// Otherwise value is kept for the next byte
	end

	// Read mux, unused bits zero
	always_comb
	begin
		readValue = 32'h00000000;
		unique case (paddr)
			BWCRC_CONTROL_ADDR:
				readValue[0] = generatorChoice_r;
			BWCRC_INPUT_ADDR:
				readValue[7:0] = crcInputByte_r;
			BWCRC_SUM_LOW_ADDR:
				readValue[7:0] = runningChecksum_r[7:0];
			BWCRC_SUM_HIGH_ADDR:
				readValue[7:0] = runningChecksum_r[15:8];
			default:
				readValue = 32'h00000000;
		endcase
	end

	// Read data captured in the setup cycle, stable during access
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prdata <= 32'h00000000;
		else if (rdAccess)
			prdata <= readValue;
	end

	// Reference fold for the checkers, in the serial form: each data
	// bit meets the bit leaving the top, so it shares nothing with the
	// stage chain above and catches a slip in it
	function automatic logic [15:0] bwcrcRefFold(input logic [15:0] sum,
		input logic [7:0] data, input logic choice);
		logic [15:0] acc;
		logic [15:0] generator_choice;
		logic feed;
		acc = sum;
		generator_choice = choice ? BWCRC_GENERATOR_CHOICE_CRC16 : BWCRC_GENERATOR_CHOICE_CCITT;
		feed = 1'b0;
		for (int j = BWCRC_STEPS - 1; j >= 0; j--)
		begin
			// Bit leaving the top meets the next data bit
			feed = acc[15] ^ data[j];
			acc = {acc[14:0], 1'b0};
			if (feed)
			begin
				acc = acc ^ generator_choice;
			end
		end
		return acc;
	endfunction

	// Helper: expected checksum after a fold in this cycle
	logic [15:0] expectSum; // Reference result, one cycle late
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			expectSum <= BWCRC_SUM_RST;
		else
			expectSum <= bwcrcRefFold(runningChecksum_r, pwdata[7:0],
				generatorChoice_r);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_fold_takes_effect: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		|=> runningChecksum_r == expectSum)
		else $error("checksum not folded on input write");
	a_zero_fold_ccitt: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h01
		&& !generatorChoice_r |=> runningChecksum_r == 16'h1021)
		else $error("CCITT fold of 01 wrong");
	a_zero_fold_crc16: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h03
		&& generatorChoice_r |=> runningChecksum_r == 16'h000A)
		else $error("CRC-16 fold of 03 wrong");
	a_sum_holds: assert property (
		!wrAccess |=> $stable(runningChecksum_r))
		else $error("checksum changed without write");
	a_input_holds: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		|=> crcInputByte_r == $past(pwdata[7:0]))
		else $error("input byte not stored");
	a_control_zero: assert property (
		rdAccess && paddr == BWCRC_CONTROL_ADDR
		|=> prdata[31:1] == 31'h00000000)
		else $error("control unused bits not zero");
	a_high_read: assert property (
		rdAccess && paddr == BWCRC_SUM_HIGH_ADDR
		|=> prdata == {24'h000000, $past(runningChecksum_r[15:8])})
		else $error("high checksum read wrong");
	a_low_read: assert property (
		rdAccess && paddr == BWCRC_SUM_LOW_ADDR
		|=> prdata == {24'h000000, $past(runningChecksum_r[7:0])})
		else $error("low checksum read wrong");
	a_low_write: assert property (
		wrAccess && laneWrite && paddr == BWCRC_SUM_LOW_ADDR
		|=> runningChecksum_r[7:0] == $past(pwdata[7:0]))
		else $error("low checksum preset lost");

	c_fold_ccitt: cover property (wrAccess && paddr == BWCRC_INPUT_ADDR
		&& !generatorChoice_r);
	c_fold_crc16: cover property (wrAccess && paddr == BWCRC_INPUT_ADDR
		&& generatorChoice_r);
	c_preset_high: cover property (wrAccess
		&& paddr == BWCRC_SUM_HIGH_ADDR);
	c_unmapped: cover property (pslverr);

	// Masked write to the input register must leave everything alone
	c_masked_input: cover property (psel && penable && pwrite
		&& !pstrb[0] && paddr == BWCRC_INPUT_ADDR);

	// Zero-wait slave: ready never drops
	a_ready_high: assert property (
		pready == 1'b1)
		else $error("ready dropped");

	// Access above the last register answers with an error
	a_err_unmapped: assert property (
		psel && penable && paddr > BWCRC_SUM_HIGH_ADDR |-> pslverr)
		else $error("no error for unmapped address");

	// Access to the input register never errors
	a_err_mapped: assert property (
		psel && penable && paddr == BWCRC_INPUT_ADDR |-> !pslverr)
		else $error("error on input register");

	// No error without a selected transfer
	a_err_idle: assert property (
		!psel |-> !pslverr)
		else $error("error while idle");

	// Input write with lane 0 masked does not fold
	a_masked_sum: assert property (
		psel && penable && pwrite && !pstrb[0] && paddr == BWCRC_INPUT_ADDR
		|=> $stable(runningChecksum_r))
		else $error("masked input write folded");

	// Input write with lane 0 masked keeps the stored byte
	a_masked_byte: assert property (
		psel && penable && pwrite && !pstrb[0] && paddr == BWCRC_INPUT_ADDR
		|=> $stable(crcInputByte_r))
		else $error("masked input write stored");

	// Unmapped write leaves the checksum alone
	a_unmapped_write: assert property (
		psel && penable && pwrite && !mapped
		|=> $stable(runningChecksum_r))
		else $error("unmapped write changed checksum");

	// High preset lands in bits 15..8
	a_high_write: assert property (
		wrAccess && laneWrite && paddr == BWCRC_SUM_HIGH_ADDR
		|=> runningChecksum_r[15:8] == $past(pwdata[7:0]))
		else $error("high checksum preset lost");

	// High preset keeps the low byte
	a_high_keeps_low: assert property (
		wrAccess && laneWrite && paddr == BWCRC_SUM_HIGH_ADDR
		|=> runningChecksum_r[7:0] == $past(runningChecksum_r[7:0]))
		else $error("high preset touched low byte");

	// Low preset keeps the high byte
	a_low_keeps_high: assert property (
		wrAccess && laneWrite && paddr == BWCRC_SUM_LOW_ADDR
		|=> runningChecksum_r[15:8] == $past(runningChecksum_r[15:8]))
		else $error("low preset touched high byte");

	// Control write stores bit 0
	a_choice_write: assert property (
		wrAccess && laneWrite && paddr == BWCRC_CONTROL_ADDR
		|=> generatorChoice_r == $past(pwdata[BWCRC_CHOICE_BIT]))
		else $error("polynomial select not stored");

	// Select bit changes only by a control write
	a_choice_holds: assert property (
		!(psel && penable && pwrite && paddr == BWCRC_CONTROL_ADDR)
		|=> $stable(generatorChoice_r))
		else $error("polynomial select changed");

	// Input byte stays unless the input register is written
	a_input_other: assert property (
		wrAccess && paddr != BWCRC_INPUT_ADDR
		|=> $stable(crcInputByte_r))
		else $error("input byte changed by other write");

	// Input register reads back the stored byte
	a_input_read: assert property (
		rdAccess && paddr == BWCRC_INPUT_ADDR
		|=> prdata == {24'h000000, $past(crcInputByte_r)})
		else $error("input byte read wrong");

	// Control register reads back the select bit
	a_control_read: assert property (
		rdAccess && paddr == BWCRC_CONTROL_ADDR
		|=> prdata[0] == $past(generatorChoice_r))
		else $error("polynomial select read wrong");

	// Holes in the map read as zero
	a_unmapped_read: assert property (
		rdAccess && !mapped |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");

	// Read data stands until the next read setup
	a_prdata_holds: assert property (
		!rdAccess |=> $stable(prdata))
		else $error("read data moved");

	// Zero byte into a cleared pair gives zero
	a_zero_fold_zero: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h00
		|=> runningChecksum_r == 16'h0000)
		else $error("fold of 00 not zero");

	// CCITT fold of 02 from a cleared pair
	a_ccitt_two: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h02
		&& !generatorChoice_r |=> runningChecksum_r == 16'h2042)
		else $error("CCITT fold of 02 wrong");

	// CCITT fold of 03 from a cleared pair
	a_ccitt_three: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h03
		&& !generatorChoice_r |=> runningChecksum_r == 16'h3063)
		else $error("CCITT fold of 03 wrong");

	// CRC-16 fold of 01 from a cleared pair
	a_crc16_one: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h01
		&& generatorChoice_r |=> runningChecksum_r == 16'h8005)
		else $error("CRC-16 fold of 01 wrong");

	// CRC-16 fold of 02 from a cleared pair
	a_crc16_two: assert property (
		wrAccess && laneWrite && paddr == BWCRC_INPUT_ADDR
		&& runningChecksum_r == 16'h0000 && pwdata[7:0] == 8'h02
		&& generatorChoice_r |=> runningChecksum_r == 16'h800F)
		else $error("CRC-16 fold of 02 wrong");

endmodule

/* File: bench/tb_top.sv */
// Self-checking APB testbench for the byte-wise CRC unit
`timescale 1ns/100ps
module tb_top;
	import bwcrc_pkg::*;
	logic clk = 0; // Bench clock
	logic reset_n = 0; // Reset, active low
	logic psel = 0; // APB select
	logic penable = 0; // APB access phase
	logic pwrite = 0; // APB direction
	logic [11:0] paddr = '0; // APB address
	logic [31:0] pwdata = '0; // APB write data
	logic [3:0] pstrb = 4'hF; // APB strobes
	logic [31:0] prdata; // APB read data
	logic pready; // APB ready
	logic pslverr; // APB error
	logic [31:0] rd; // Data taken at end of transfer
	logic err; // Error taken at end of transfer
	int err_count = 0; // Mismatches
	int tests_run = 0; // Comparisons
	int cyc = 0; // Cycles since start
	bwcrc_byte_wise_crc16_unit uut (.clk(clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// Clock of 20 ns period
	initial
	begin
		forever #10 clk = ~clk;
	end
	// Cut a hung run short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			end_of_test();
		end
	end
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Read a register and compare it
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'hF);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	// Reset values, then control bits above bit 0
	task automatic t_reset();
		rdc(BWCRC_CONTROL_ADDR, 32'h0);
		rdc(BWCRC_INPUT_ADDR, 32'h0);
		rdc(BWCRC_SUM_LOW_ADDR, 32'h0);
		rdc(BWCRC_SUM_HIGH_ADDR, 32'h0);
		apb(1'b1, BWCRC_CONTROL_ADDR, 32'hFF, 4'hF);
		rdc(BWCRC_CONTROL_ADDR, 32'h1);
		$display("test reset done");
	endtask
	// Four bytes folded in sequence from a cleared pair
	task automatic t_vec(input logic p, input logic [15:0] e [4]);
		logic [7:0] b [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
		apb(1'b1, BWCRC_CONTROL_ADDR, {31'h0, p}, 4'hF);
		apb(1'b1, BWCRC_SUM_LOW_ADDR, 32'h0, 4'hF);
		apb(1'b1, BWCRC_SUM_HIGH_ADDR, 32'h0, 4'hF);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, BWCRC_INPUT_ADDR, {24'h0, b[i]}, 4'hF);
			rdc(BWCRC_SUM_HIGH_ADDR, {24'h0, e[i][15:8]});
			rdc(BWCRC_SUM_LOW_ADDR, {24'h0, e[i][7:0]});
			rdc(BWCRC_INPUT_ADDR, {24'h0, b[i]});
		end
		$display("test vector done");
	endtask
	// One byte folded from a cleared pair
	task automatic t_one(input logic p, input logic [7:0] b,
		input logic [15:0] e);
		apb(1'b1, BWCRC_CONTROL_ADDR, {31'h0, p}, 4'hF);
		apb(1'b1, BWCRC_SUM_LOW_ADDR, 32'h0, 4'hF);
		apb(1'b1, BWCRC_SUM_HIGH_ADDR, 32'h0, 4'hF);
		apb(1'b1, BWCRC_INPUT_ADDR, {24'h0, b}, 4'hF);
		rdc(BWCRC_SUM_HIGH_ADDR, {24'h0, e[15:8]});
		rdc(BWCRC_SUM_LOW_ADDR, {24'h0, e[7:0]});
		$display("test single byte %h done", b);
	endtask
	// Preset, masked write and unmapped address
	task automatic t_misc();
		apb(1'b1, BWCRC_SUM_HIGH_ADDR, 32'hAB, 4'hF);
		apb(1'b1, BWCRC_SUM_LOW_ADDR, 32'hCD, 4'hF);
		apb(1'b1, BWCRC_SUM_HIGH_ADDR, 32'h55, 4'hE);
		apb(1'b1, BWCRC_INPUT_ADDR, 32'h5A, 4'hE);
		rdc(BWCRC_SUM_HIGH_ADDR, 32'hAB);
		rdc(BWCRC_SUM_LOW_ADDR, 32'hCD);
		rdc(BWCRC_INPUT_ADDR, 32'h12);
		apb(1'b1, 12'h010, 32'hFF, 4'hF);
		chk("write error", 32'h1, {31'h0, err});
		rdc(BWCRC_SUM_LOW_ADDR, 32'hCD);
		rdc(12'h010, 32'h0);
		chk("read error", 32'h1, {31'h0, err});
		$display("test misc done");
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		t_reset();
		t_one(1'b0, 8'h00, 16'h0000);
		t_one(1'b0, 8'h01, 16'h1021);
		t_one(1'b0, 8'h02, 16'h2042);
		t_one(1'b0, 8'h03, 16'h3063);
		t_one(1'b1, 8'h00, 16'h0000);
		t_one(1'b1, 8'h01, 16'h8005);
		t_one(1'b1, 8'h02, 16'h800F);
		t_one(1'b1, 8'h03, 16'h000A);
		t_vec(1'b0, '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA});
		t_vec(1'b1, '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43});
		t_misc();
		end_of_test();
	end
endmodule
